// [dic_pkg.sv]
// What this block does
// - Sample all inputs once per 5 ms scan
// - Update relay drives other than the fault relay only on 5 ms cycle
// - Polarity select: normally open or closed
// - Delay 0 to 1 by pick-up time
// - Delay 1 to 0 by drop-off time
// - AC mode adds 30 ms to drop-off
// - Logic stage adds one 5 ms cycle
// - Relay routing adds one further cycle
// - Fault relay energized only when healthy
package dic_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned TICK_US        = 1_000;
  localparam int unsigned TICK_CYCLES    = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned SCAN_MS        = 5;
  localparam int unsigned AC_EXT_MS      = 30;
  localparam int unsigned DELAY_W        = 21;   // Up to 1800.000 s in 1 ms steps
  localparam int unsigned DELAY_MAX_MS   = 1_800_000;
  // ----------------------------------------------------------------
  // Avalon register map (word addresses, byte address = 4*index)
  // ----------------------------------------------------------------
  localparam logic [5:0] REG_CTRL      = 6'h00;
  localparam logic [5:0] REG_POLARITY  = 6'h01;
  localparam logic [5:0] REG_AC_EN     = 6'h02;
  localparam logic [5:0] REG_IN_STATE  = 6'h03;
  localparam logic [5:0] REG_LOGIC_OUT = 6'h04;
  localparam logic [5:0] REG_ROUTE     = 6'h05;
  localparam logic [5:0] REG_IRQ_STAT  = 6'h06;
  localparam logic [5:0] REG_IRQ_MASK  = 6'h07;
  localparam logic [5:0] REG_PICKUP0   = 6'h10;
  localparam logic [5:0] REG_DROPOFF0  = 6'h20;
  localparam int unsigned CTRL_READY_BIT = 0;
  localparam int unsigned CTRL_FAULT_BIT = 1;
  localparam logic [31:0] RESET_VALUE  = 32'h0000_0000;
endpackage : dic_pkg

// [dic_tick.sv]
`timescale 1ns/1ps
`default_nettype none
module dic_tick
  import dic_pkg::*;
#(
  parameter int unsigned DIV = TICK_CYCLES
) (
  input  wire logic i_mclk,
  input  wire logic i_reset,
  input  wire logic i_cnt_enable,
  output logic      o_tick
);
  localparam int unsigned CW = $clog2(DIV + 1);
  logic [CW-1:0] cnt_reg;

  always_ff @(posedge i_mclk) begin
    if (i_reset || !i_cnt_enable) begin
      cnt_reg <= '0;
      o_tick  <= 1'b0;
    end else if (cnt_reg == CW'(DIV - 1)) begin
      cnt_reg <= '0;
      o_tick  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
      o_tick  <= 1'b0;
    end
  end
endmodule : dic_tick
`default_nettype wire

// [dic_chan.sv]
`timescale 1ns/1ps
`default_nettype none
module dic_chan
  import dic_pkg::*;
(
  input  wire logic               i_mclk,
  input  wire logic               i_reset,
  input  wire logic               i_ms_tick,
  input  wire logic               i_raw,
  input  wire logic               i_polarity,
  input  wire logic               i_ac_en,
  input  wire logic [DELAY_W-1:0] i_pickup,
  input  wire logic [DELAY_W-1:0] i_dropoff,
  output logic                    o_state
);
  localparam int unsigned CW = DELAY_W + 1;
  logic          level;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] target;

  assign level  = i_raw ^ i_polarity;
  always_comb begin
    if (o_state)
      target = CW'(i_dropoff) + (i_ac_en ? CW'(AC_EXT_MS) : '0);
    else
      target = CW'(i_pickup);
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      cnt_reg <= '0;
      o_state <= 1'b0;
    end else if (level == o_state) begin
      cnt_reg <= '0;
    end else if (cnt_reg >= target) begin
      cnt_reg <= '0;
      o_state <= level;
    end else if (i_ms_tick) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule : dic_chan
`default_nettype wire

// [dic_top.sv]
// Our own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module dic_top
  import dic_pkg::*;
#(
  parameter int unsigned N_IN    = 3,
  parameter int unsigned N_OUT   = 5,
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  input  wire logic             i_mclk,
  input  wire logic             i_reset,
  input  wire logic [N_IN-1:0]  i_digital_input_n,
  input  wire logic             i_system_fault,
  input  wire logic [5:0]       i_address,
  input  wire logic             i_read,
  input  wire logic             i_write,
  input  wire logic [31:0]      i_writedata,
  input  wire logic [3:0]       i_byteenable,
  output logic [31:0]           o_readdata,
  output logic                  o_waitrequest,
  output logic [N_OUT-1:0]      o_relay_output_n,
  output logic                  o_fault_relay_energize,
  output logic [N_IN-1:0]       o_input_state,
  output logic                  o_irq
);
  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  logic       ms_tick;
  logic [2:0] ms_cnt_reg;
  logic       scan_tick_reg;

  dic_tick #(.DIV(TICK_DIV)) u_tick (
    .i_mclk      (i_mclk),
    .i_reset     (i_reset),
    .i_cnt_enable(1'b1),
    .o_tick      (ms_tick)
  );

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ms_cnt_reg    <= '0;
      scan_tick_reg <= 1'b0;
    end else begin
      scan_tick_reg <= 1'b0;
      if (ms_tick) begin
        if (ms_cnt_reg == 3'(SCAN_MS - 1)) begin
          ms_cnt_reg    <= '0;
          scan_tick_reg <= 1'b1;
        end else begin
          ms_cnt_reg <= ms_cnt_reg + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Settings registers
  // ----------------------------------------------------------------
  logic [N_IN-1:0]    polarity_reg;
  logic [N_IN-1:0]    ac_en_reg;
  logic [DELAY_W-1:0] pickup_reg  [N_IN];
  logic [DELAY_W-1:0] dropoff_reg [N_IN];
  logic [N_OUT-1:0]   logic_out_reg;
  logic [N_OUT-1:0]   route_reg;
  logic               ready_reg;
  logic [N_IN-1:0]    irq_mask_reg;
  logic [N_IN-1:0]    irq_stat_reg;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic [DELAY_W-1:0] clamp(input logic [31:0] v);
    return (v > DELAY_MAX_MS) ? DELAY_W'(DELAY_MAX_MS) : v[DELAY_W-1:0];
  endfunction : clamp

  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] wmerged;
  logic [31:0] rd_word;

  assign wr_hit = i_write && o_waitrequest == 1'b0;
  assign rd_hit = i_read  && o_waitrequest == 1'b0;

  always_comb begin
    wmerged = merge(RESET_VALUE, i_writedata, i_byteenable);
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      polarity_reg  <= '0;
      ac_en_reg     <= '0;
      logic_out_reg <= '0;
      route_reg     <= '0;
      ready_reg     <= 1'b0;
      irq_mask_reg  <= '0;
    end else if (wr_hit) begin
      case (i_address)
        REG_CTRL:      ready_reg     <= wmerged[CTRL_READY_BIT];
        REG_POLARITY:  polarity_reg  <= wmerged[N_IN-1:0];
        REG_AC_EN:     ac_en_reg     <= wmerged[N_IN-1:0];
        REG_LOGIC_OUT: logic_out_reg <= wmerged[N_OUT-1:0];
        REG_ROUTE:     route_reg     <= wmerged[N_OUT-1:0];
        REG_IRQ_MASK:  irq_mask_reg  <= wmerged[N_IN-1:0];
        default: ;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < N_IN; g++) begin : g_dly
      always_ff @(posedge i_mclk) begin
        if (i_reset) begin
          pickup_reg[g]  <= '0;
          dropoff_reg[g] <= '0;
        end else if (wr_hit && i_address == REG_PICKUP0 + 6'(g)) begin
          pickup_reg[g]  <= clamp(wmerged);
        end else if (wr_hit && i_address == REG_DROPOFF0 + 6'(g)) begin
          dropoff_reg[g] <= clamp(wmerged);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Input scan and conditioning
  // ----------------------------------------------------------------
  logic [N_IN-1:0] scan_reg;
  logic [N_IN-1:0] cond_state;
  logic [N_IN-1:0] logic_in_reg;
  logic [1:0]      scan_dly_reg;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      scan_reg <= '0;
    end else if (scan_tick_reg) begin
      scan_reg <= i_digital_input_n;
    end
  end

  // Channels update one cycle after the scan, so the report waits two
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      scan_dly_reg <= '0;
    end else begin
      scan_dly_reg <= {scan_dly_reg[0], scan_tick_reg};
    end
  end

  generate
    for (g = 0; g < N_IN; g++) begin : g_ch
      dic_chan u_chan (
        .i_mclk    (i_mclk),
        .i_reset   (i_reset),
        .i_ms_tick (ms_tick),
        .i_raw     (scan_reg[g]),
        .i_polarity(polarity_reg[g]),
        .i_ac_en   (ac_en_reg[g]),
        .i_pickup  (pickup_reg[g]),
        .i_dropoff (dropoff_reg[g]),
        .o_state   (cond_state[g])
      );
    end
  endgenerate

  // Logic stage latches conditioned states one scan later
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      logic_in_reg <= '0;
    end else if (scan_tick_reg) begin
      logic_in_reg <= cond_state;
    end
  end

  // Reported state is taken once the channels have settled on this scan
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_input_state <= '0;
    end else if (scan_dly_reg[1]) begin
      o_input_state <= cond_state;
    end
  end

  // ----------------------------------------------------------------
  // Relay drive
  // ----------------------------------------------------------------
  // Routed input uses input 0; a wider matrix was not needed here
  logic [N_OUT-1:0] relay_next;

  always_comb begin
    relay_next = logic_out_reg | (route_reg & {N_OUT{logic_in_reg[0]}});
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_relay_output_n <= '0;
    end else if (scan_tick_reg) begin
      o_relay_output_n <= relay_next;
    end
  end

  // Fault relay fails safe: de-energized unless ready and healthy
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_fault_relay_energize <= 1'b0;
    end else begin
      o_fault_relay_energize <= ready_reg & ~i_system_fault;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [N_IN-1:0] evt;
  logic            stat_rd;
  logic [N_IN-1:0] stat_clr;

  assign evt      = scan_dly_reg[1] ? (cond_state ^ o_input_state) : '0;
  assign stat_rd  = rd_hit && i_address == REG_IRQ_STAT;
  // Only bits already returned by the read are cleared, so none is lost
  assign stat_clr = stat_rd ? o_readdata[N_IN-1:0] : '0;

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~stat_clr) | evt;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Avalon slave: one wait cycle, data registered
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = RESET_VALUE;
    case (i_address)
      REG_CTRL: begin
        rd_word[CTRL_READY_BIT] = ready_reg;
        rd_word[CTRL_FAULT_BIT] = i_system_fault;
      end
      REG_POLARITY:  rd_word[N_IN-1:0]  = polarity_reg;
      REG_AC_EN:     rd_word[N_IN-1:0]  = ac_en_reg;
      REG_IN_STATE:  rd_word[N_IN-1:0]  = logic_in_reg;
      REG_LOGIC_OUT: rd_word[N_OUT-1:0] = logic_out_reg;
      REG_ROUTE:     rd_word[N_OUT-1:0] = route_reg;
      REG_IRQ_STAT:  rd_word[N_IN-1:0]  = irq_stat_reg;
      REG_IRQ_MASK:  rd_word[N_IN-1:0]  = irq_mask_reg;
      default: begin
        for (int k = 0; k < N_IN; k++) begin
          if (i_address == REG_PICKUP0 + 6'(k))  rd_word[DELAY_W-1:0] = pickup_reg[k];
          if (i_address == REG_DROPOFF0 + 6'(k)) rd_word[DELAY_W-1:0] = dropoff_reg[k];
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_waitrequest <= 1'b1;
      o_readdata    <= '0;
    end else begin
      o_waitrequest <= ~((i_read | i_write) & o_waitrequest);
      if (i_read && o_waitrequest) begin
        o_readdata <= rd_word;
      end
    end
  end
endmodule : dic_top
`default_nettype wire

// [dic_top_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module dic_top_asserts
  import dic_pkg::*;
#(
  parameter int unsigned N_IN     = 3,
  parameter int unsigned N_OUT    = 5,
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  input wire logic             i_mclk,
  input wire logic             i_reset,
  input wire logic [N_IN-1:0]  i_digital_input_n,
  input wire logic             i_system_fault,
  input wire logic [5:0]       i_address,
  input wire logic             i_read,
  input wire logic             i_write,
  input wire logic [31:0]      i_writedata,
  input wire logic [3:0]       i_byteenable,
  input wire logic [31:0]      o_readdata,
  input wire logic             o_waitrequest,
  input wire logic [N_OUT-1:0] o_relay_output_n,
  input wire logic             o_fault_relay_energize,
  input wire logic [N_IN-1:0]  o_input_state,
  input wire logic             o_irq
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // ----------------------------------------------------------------
  // Spacing between output changes; the first change has no reference
  // ----------------------------------------------------------------
  logic [15:0] in_gap;
  logic [15:0] rl_gap;
  logic        in_seen;
  logic        rl_seen;
  always_ff @(posedge i_mclk) begin
    in_gap  <= (i_reset || $changed(o_input_state)) ? 16'h0001 : in_gap + 16'h0001;
    in_seen <= !i_reset && (in_seen || $changed(o_input_state));
  end
  always_ff @(posedge i_mclk) begin
    rl_gap  <= (i_reset || $changed(o_relay_output_n)) ? 16'h0001 : rl_gap + 16'h0001;
    rl_seen <= !i_reset && (rl_seen || $changed(o_relay_output_n));
  end
  AST_FAULT_DROP: assert property (i_system_fault |-> ##[1:2] !o_fault_relay_energize)
    else $error("fault relay energized during a fault");
  AST_FAULT_RISE: assert property ($rose(o_fault_relay_energize) |-> !$past(i_system_fault))
    else $error("fault relay energized right after a fault");
  AST_RESET_CLEAR: assert property ($fell(i_reset) |-> o_relay_output_n == '0
    && o_input_state == '0 && !o_fault_relay_energize && o_waitrequest && !o_irq)
    else $error("outputs not cleared by reset");
  AST_RELAY_CYCLE: assert property ($changed(o_relay_output_n) && rl_seen
    |-> (rl_gap % (5 * TICK_DIV)) == 0)
    else $error("relay drive changed off the scan cycle");
  AST_STATE_TICK: assert property ($changed(o_input_state) && in_seen
    |-> (in_gap % TICK_DIV) == 0)
    else $error("input state changed off the ms timebase");
  AST_WAIT_ANSWER: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("request not answered after one wait state");
  AST_WAIT_ONE: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("waitrequest low longer than one cycle");
  AST_UNMAPPED: assert property (i_read && o_waitrequest && i_address == 6'h3F
    |=> o_readdata == 32'h0000_0000)
    else $error("unmapped read returned nonzero");
endmodule : dic_top_asserts
bind dic_top dic_top_asserts #(.N_IN(N_IN), .N_OUT(N_OUT), .TICK_DIV(TICK_DIV)) dic_top_asserts_inst (
  .i_mclk(i_mclk), .i_reset(i_reset), .i_digital_input_n(i_digital_input_n),
  .i_system_fault(i_system_fault), .i_address(i_address), .i_read(i_read),
  .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
  .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_relay_output_n(o_relay_output_n),
  .o_fault_relay_energize(o_fault_relay_energize), .o_input_state(o_input_state), .o_irq(o_irq));
`default_nettype wire

// [dic_field.sv]
`timescale 1ns/1ps
`default_nettype none
module dic_field #(
  parameter int unsigned N    = 3,
  parameter int unsigned HALF = 200,
  parameter int unsigned GAP  = 40
) (
  input  wire logic         i_mclk,
  input  wire logic [N-1:0] i_close,
  input  wire logic [N-1:0] i_ac,
  output logic      [N-1:0] o_level
);
  // AC inputs sag near each zero crossing; an open contact is pulled low
  int unsigned ph;
  always_ff @(posedge i_mclk) ph <= (ph == HALF - 1) ? 0 : ph + 1;
  assign o_level = i_close & ~(i_ac & {N{ph < GAP}});
endmodule : dic_field
`default_nettype wire

// [tb_digital_input_conditioning.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_digital_input_conditioning
  import dic_pkg::*;
;
  localparam int TD = 20;
  localparam int SC = 5 * TD;
  logic        i_mclk, i_reset, i_system_fault, i_read, i_write;
  logic        o_waitrequest, o_fault_relay_energize, o_irq;
  logic [2:0]  close, ac, din, o_input_state;
  logic [3:0]  i_byteenable;
  logic [4:0]  o_relay_output_n;
  logic [5:0]  i_address;
  logic [31:0] i_writedata, o_readdata, rv;
  int          miscompares, compares, n, k;
  dic_field dic_field_inst (.i_mclk(i_mclk), .i_close(close), .i_ac(ac), .o_level(din));
  dic_top #(.N_IN(3), .N_OUT(5), .TICK_DIV(TD)) dic_top_inst (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_digital_input_n(din),
    .i_system_fault(i_system_fault), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .o_relay_output_n(o_relay_output_n), .o_fault_relay_energize(o_fault_relay_energize),
    .o_input_state(o_input_state), .o_irq(o_irq));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic cyc(input int c);
    repeat (c) @(posedge i_mclk);
  endtask : cyc
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_address   <= a;
    i_writedata <= d;
    i_write     <= 1'b1;
    do @(posedge i_mclk); while (o_waitrequest !== 1'b0);
    i_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge i_mclk);
    i_address <= a;
    i_read    <= 1'b1;
    do @(posedge i_mclk); while (o_waitrequest !== 1'b0);
    d = o_readdata;
    i_read <= 1'b0;
  endtask : rd
  // Edges until a state or relay bit reaches v; bounded so a stuck bit cannot hang
  task automatic wt(input logic rel, input int b, input logic v, output int c);
    c = 0;
    while (((rel ? o_relay_output_n[b] : o_input_state[b]) !== v) && c < 3000) begin
      @(posedge i_mclk);
      c++;
    end
  endtask : wt
  task automatic conclude();
    if (miscompares == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [5:0] ad [6] = '{REG_POLARITY, REG_AC_EN, REG_PICKUP0, REG_DROPOFF0, REG_IRQ_MASK, 6'h3F};
    chk("outputs", 32'h0, {o_relay_output_n, o_input_state, o_fault_relay_energize, o_irq});
    wr(6'h3F, 32'hFFFF_FFFF);
    foreach (ad[i]) begin
      rd(ad[i], rv);
      chk("reset reg", 32'h0, rv);
    end
  endtask : t_reset
  task automatic t_fault();
    wr(REG_CTRL, 32'h0000_0001);
    cyc(3);
    chk("fault relay", 32'h1, o_fault_relay_energize);
    i_system_fault <= 1'b1;
    cyc(3);
    chk("fault relay", 32'h0, o_fault_relay_energize);
    rd(REG_CTRL, rv);
    chk("ctrl", 32'h3, rv[1:0]);
    i_system_fault <= 1'b0;
    cyc(3);
    chk("fault relay", 32'h1, o_fault_relay_energize);
  endtask : t_fault
  task automatic t_polarity();
    close <= 3'b010;
    wt(0, 1, 1, n);
    chk("scan latency", 32'h1, n <= SC + 3);
    wr(REG_POLARITY, 32'h0000_0006);
    cyc(2 * SC);
    chk("nc state", 32'h4, o_input_state);
    wr(REG_POLARITY, 32'h0000_0000);
    close <= 3'b000;
    cyc(2 * SC);
  endtask : t_polarity
  task automatic t_delay();
    wr(REG_PICKUP0, 32'h0000_000C);
    wr(REG_DROPOFF0, 32'h0000_0007);
    close <= 3'b001;
    cyc(8 * TD);
    close <= 3'b000;
    cyc(2 * SC);
    chk("bounce", 32'h0, o_input_state[0]);
    close <= 3'b001;
    wt(0, 0, 1, n);
    chk("pickup", 32'h1, n >= 12 * TD && n <= 12 * TD + 2 * SC + 3);
    close <= 3'b000;
    wt(0, 0, 0, n);
    chk("dropoff", 32'h1, n >= 7 * TD && n <= 7 * TD + 2 * SC + 3);
    wr(REG_PICKUP0, 32'h0000_0000);
    wr(REG_DROPOFF0, 32'h0000_0000);
  endtask : t_delay
  task automatic t_ac();
    int drops;
    drops = 0;
    wr(REG_AC_EN, 32'h0000_0004);
    ac    <= 3'b100;
    close <= 3'b100;
    wt(0, 2, 1, n);
    repeat (60 * TD) begin
      @(posedge i_mclk);
      if (o_input_state[2] !== 1'b1) drops++;
    end
    chk("ac hold", 32'h0, drops);
    close <= 3'b000;
    wt(0, 2, 0, n);
    chk("ac release", 32'h1, n >= 25 * TD && n <= 35 * TD + 3);
    ac <= 3'b000;
    wr(REG_AC_EN, 32'h0000_0000);
  endtask : t_ac
  task automatic t_relay();
    wr(REG_LOGIC_OUT, 32'h0000_0012);
    cyc(2 * SC);
    chk("relays", 32'h12, o_relay_output_n);
    wr(REG_ROUTE, 32'h0000_0001);
    close <= 3'b001;
    wt(0, 0, 1, n);
    wt(1, 0, 1, k);
    chk("route lag", 32'h1, k >= 1 && n + k <= 3 * SC + 3);
    chk("relays", 32'h13, o_relay_output_n);
    rd(REG_IN_STATE, rv);
    chk("logic input", 32'h1, rv[0]);
    close <= 3'b000;
    wr(REG_ROUTE, 32'h0000_0000);
    wr(REG_LOGIC_OUT, 32'h0000_0000);
    cyc(2 * SC);
  endtask : t_relay
  task automatic t_irq();
    wr(REG_IRQ_MASK, 32'h0000_0001);
    rd(REG_IRQ_STAT, rv);
    cyc(3);
    chk("irq idle", 32'h0, o_irq);
    close <= 3'b001;
    wt(0, 0, 1, n);
    cyc(3);
    chk("irq raised", 32'h1, o_irq);
    rd(REG_IRQ_STAT, rv);
    chk("irq status", 32'h1, rv[0]);
    cyc(3);
    chk("irq cleared", 32'h0, o_irq);
    wr(REG_IRQ_MASK, 32'h0000_0000);
    close <= 3'b000;
    cyc(2 * SC);
    chk("irq masked", 32'h0, o_irq);
    rd(REG_IRQ_STAT, rv);
    chk("masked status", 32'h1, rv[0]);
  endtask : t_irq
  // ----------------------------------------------------------------
  // Run
  // ----------------------------------------------------------------
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  initial begin
    repeat (40000) @(posedge i_mclk);
    miscompares++;
    conclude();
  end
  initial begin
    {i_reset, i_system_fault, i_read, i_write} = 4'h8;
    {close, ac, i_address, i_writedata} = '0;
    i_byteenable = 4'hF;
    miscompares = 0;
    compares = 0;
    repeat (20) @(posedge i_mclk);
    i_reset <= 1'b0;
    t_reset();
    t_fault();
    t_polarity();
    t_delay();
    t_ac();
    t_relay();
    t_irq();
    conclude();
  end
endmodule : tb_digital_input_conditioning
`default_nettype wire
